// ---- hw/nmx_exception.sv ----
// nonmaskable exception logic: mask flag, stop wake-up, illegal opcode trap,
// software trap sequencing, maskable resolution and register stacking
// assumes a cpu sequencer on the same clock that reports boundaries,
// fetches and condition code writes, and pushes bytes on request
//
// What this block does
// - only software clears the mask flag
// - hardware sets flag on reset or pin recognition
// - flag is set after any reset
// - stacked condition codes keep flag clear, then set
// - flag is a set-reset element, bit 6 clears
// - writing a one leaves the flag unchanged
// - stop mode exits on reset or either pin
// - flag clear: pin wake goes to service
// - flag set: pin wake continues after stop
// - undefined opcode requests the illegal-opcode vector
// - detection covers all four opcode map pages
// - illegal trap stacks the offending opcode address
// - probe opcode legal only in special modes
// - trap waits for no pending; blocks until vector
// - trap stacks, sets global mask, never masked
// - twenty sources gated by global mask, all but the irq pin source by local enables
// - fixed priority with one promoted source
// - promotion field written only under global mask
// - push nine bytes in fixed order
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nmx_exception import nmx_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // device pins
  input wire logic nonmaskable_request_pin_n,
  input wire logic irq_pin_n,
  // cpu sequencer status
  input wire logic special_mode,
  input wire logic global_mask,
  input wire logic insn_boundary,
  input wire logic stop_exec,
  input wire logic [19:0] src_req,
  // opcode fetch
  input wire logic op_fetch,
  input wire logic [1:0] op_page,
  input wire logic [7:0] op_code,
  input wire logic op_implemented,
  input wire logic [15:0] op_addr,
  // condition code writes (transfer or exception return)
  input wire logic ccr_write,
  input wire logic [7:0] ccr_wdata,
  // software trap
  input wire logic software_trap_op_start,
  input wire logic vector_fetched,
  output logic trap_fetch_ok,
  // exception entry and stacking
  output logic exc_take,
  output nmx_exc_t exc_kind,
  output logic [15:0] exc_return_addr,
  output logic [4:0] exc_src,
  output logic push_valid,
  input wire logic push_ready,
  output nmx_push_t push_sel,
  output logic push_ccr_x,
  output logic set_global_mask,
  output logic vector_req,
  // stop control
  output logic clk_run,
  output logic resume_pulse,
  output logic mask_flag
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic axi_hit(input logic [31:0] a, input logic [3:0] ofs);
    axi_hit = (a[31:4] == 28'h0000000) && (a[3:0] == ofs);
  endfunction
  function automatic logic [4:0] pick_src(input logic [19:0] v);
    pick_src = 5'h00;
    for (int i = NMX_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick_src = 5'(i);
      end
    end
  endfunction
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum {NMX_RUN, NMX_STOP, NMX_STACK, NMX_VEC} nmx_state_t;
  nmx_state_t state;
  logic [2:0] nm_sync;
  logic [2:0] irq_sync;
  logic nm_low;
  logic irq_low;
  logic [3:0] psel;
  logic [19:0] local_en;
  logic illegal_pend;
  logic [15:0] illegal_addr;
  logic [3:0] push_idx;
  logic aw_got;
  logic w_got;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  // ------------------------------------------------------------
  // pin synchronisers: a change counts once stages 2 and 3 agree
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nm_sync <= 3'h7;
      irq_sync <= 3'h7;
      nm_low <= 1'b0;
      irq_low <= 1'b0;
    end else begin
      nm_sync <= {nm_sync[1:0], nonmaskable_request_pin_n};
      irq_sync <= {irq_sync[1:0], irq_pin_n};
      if (nm_sync[1] == nm_sync[2]) nm_low <= !nm_sync[2];
      if (irq_sync[1] == irq_sync[2]) irq_low <= !irq_sync[2];
    end
  end
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic probe_op = (op_page == NMX_PAGE_BASE) && (op_code == NMX_OP_PROBE);
  wire logic op_illegal = probe_op ? !special_mode : !op_implemented;
  wire logic nm_req = nm_low && !mask_flag;
  wire logic [19:0] gated = global_mask ? 20'h00000 :
                            (src_req & (local_en | (20'h00001 << NMX_SRC_IRQ_PIN)));
  wire logic [4:0] promo = (psel == NMX_PSEL_RESERVED) ? NMX_SRC_IRQ_PIN : {1'b0, psel};
  wire logic promo_hit = gated[promo];
  wire logic [4:0] m_src = promo_hit ? promo : pick_src(gated);
  wire logic m_req = |gated;
  wire logic at_bound = (state == NMX_RUN) && insn_boundary;
  wire logic take_ill = at_bound && illegal_pend;
  wire logic take_nm = at_bound && !illegal_pend && nm_req;
  wire logic take_m = at_bound && !illegal_pend && !nm_req && m_req;
  wire logic take_trap = (state == NMX_RUN) && software_trap_op_start && !at_bound;
  wire logic wake_svc = (state == NMX_STOP) && nm_req;
  wire logic wake_cont = (state == NMX_STOP) && !nm_req && (nm_low || irq_low);
  wire logic push_fire = push_valid && push_ready;
  wire logic last_push = push_fire && (push_idx == NMX_LAST_PUSH);
  wire logic nm_ack = last_push && (exc_kind == NMX_EXC_NONMASK);
  wire logic x_clear = ccr_write && !ccr_wdata[NMX_CCR_X_BIT];
  // ------------------------------------------------------------
  // handshake outputs
  // ------------------------------------------------------------
  assign exc_take = take_ill || take_nm || take_m || take_trap || wake_svc;
  assign push_valid = (state == NMX_STACK);
  assign push_sel = nmx_push_t'(push_idx);
  assign set_global_mask = last_push;
  assign vector_req = (state == NMX_VEC);
  assign clk_run = (state != NMX_STOP);
  assign resume_pulse = wake_cont;
  assign trap_fetch_ok = (state == NMX_RUN) && !illegal_pend && !nm_req && !m_req;
  // ------------------------------------------------------------
  // nonmaskable mask flag: set-reset, set wins
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_flag <= 1'b1;
    end else if (nm_ack) begin
      mask_flag <= 1'b1;
    end else if (x_clear) begin
      mask_flag <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // illegal opcode capture
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_pend <= 1'b0;
      illegal_addr <= 16'h0000;
    end else if (op_fetch && op_illegal) begin
      illegal_pend <= 1'b1;
      illegal_addr <= op_addr;
    end else if (take_ill) begin
      illegal_pend <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // exception sequencer
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= NMX_RUN;
      push_idx <= 4'h0;
      exc_kind <= NMX_EXC_NONMASK;
      exc_return_addr <= 16'h0000;
      exc_src <= 5'h00;
      push_ccr_x <= 1'b1;
    end else begin
      case (state)
        NMX_RUN: begin
          if (take_ill) begin
            exc_kind <= NMX_EXC_ILLEGAL;
            exc_return_addr <= illegal_addr;
          end else if (take_nm) begin
            exc_kind <= NMX_EXC_NONMASK;
          end else if (take_m) begin
            exc_kind <= NMX_EXC_MASKABLE;
            exc_src <= m_src;
          end else if (take_trap) begin
            exc_kind <= NMX_EXC_TRAP;
          end
          if (exc_take) begin
            state <= NMX_STACK;
            push_idx <= 4'h0;
            push_ccr_x <= mask_flag;
          end else if (stop_exec) begin
            state <= NMX_STOP;
          end
        end
        NMX_STOP: begin
          if (wake_svc) begin
            exc_kind <= NMX_EXC_NONMASK;
            push_ccr_x <= mask_flag;
            push_idx <= 4'h0;
            state <= NMX_STACK;
          end else if (wake_cont) begin
            state <= NMX_RUN;
          end
        end
        NMX_STACK: begin
          if (last_push) begin
            state <= NMX_VEC;
          end else if (push_fire) begin
            push_idx <= push_idx + 4'h1;
          end
        end
        NMX_VEC: begin
          if (vector_fetched) state <= NMX_RUN;
        end
        default: state <= NMX_RUN;
      endcase
    end
  end
  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  wire logic wr_go = aw_got && w_got && !bvalid;
  wire logic wr_ctrl = axi_hit(aw_addr_q, NMX_OFS_CTRL);
  wire logic wr_en = axi_hit(aw_addr_q, NMX_OFS_LOCAL_EN);
  wire logic wr_stat = axi_hit(aw_addr_q, NMX_OFS_STATUS);
  wire logic [31:0] status_word = {4'h0, local_en & src_req, 3'h0, nm_low,
                                   m_req, (state == NMX_VEC), (state == NMX_STOP), mask_flag};
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      bvalid <= 1'b0;
      bresp <= NMX_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data_q <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_ctrl || wr_en || wr_stat) ? NMX_RESP_OKAY : NMX_RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psel <= NMX_PSEL_RST;
      local_en <= NMX_LOCAL_EN_RST;
    end else if (wr_go) begin
      if (wr_ctrl && global_mask) psel <= w_data_q[NMX_PSEL_W-1:0];
      if (wr_en) local_en <= w_data_q[NMX_NUM_SRC-1:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= NMX_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= NMX_RESP_OKAY;
      if (axi_hit(araddr, NMX_OFS_CTRL)) rdata <= {28'h0000000, psel};
      else if (axi_hit(araddr, NMX_OFS_STATUS)) rdata <= status_word;
      else if (axi_hit(araddr, NMX_OFS_LOCAL_EN)) rdata <= {12'h000, local_en};
      else begin
        rdata <= 32'h00000000;
        rresp <= NMX_RESP_DECERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_nm_entry;
    (state == NMX_STACK && exc_kind == NMX_EXC_NONMASK) ##0 last_push;
  endsequence
  AST_RESET_SETS_FLAG: assert property (@(posedge aclk) $rose(aresetn) |-> mask_flag)
    else $error("mask flag not set after reset");
  AST_NO_SW_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (!$past(mask_flag) && mask_flag) |-> $past(nm_ack))
    else $error("mask flag set without pin acknowledge");
  AST_CLEAR_ON_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (x_clear && !nm_ack) |=> !mask_flag)
    else $error("mask flag not cleared by write");
  AST_ACK_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
    s_nm_entry |-> !push_ccr_x ##1 mask_flag)
    else $error("pin entry stacked flag set or flag not set after");
  AST_STOP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == NMX_STOP && !nm_low && !irq_low) |=> state == NMX_STOP)
    else $error("left stop without a wake source");
  AST_WAKE_CONT: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == NMX_STOP && nm_low && mask_flag) |-> resume_pulse ##1 (state == NMX_RUN))
    else $error("masked pin did not continue from stop");
  AST_WAKE_SVC: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == NMX_STOP && nm_low && !mask_flag) |=> (state == NMX_STACK && push_idx == 4'h0))
    else $error("unmasked pin wake did not start stacking");
  AST_ILL_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    take_ill |=> (exc_kind == NMX_EXC_ILLEGAL && exc_return_addr == $past(illegal_addr)))
    else $error("illegal trap return address wrong");
  AST_PROBE: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_fetch && probe_op && !special_mode && !illegal_pend && !take_ill) |=> illegal_pend)
    else $error("probe opcode not trapped in normal mode");
  AST_VEC_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == NMX_VEC && !vector_fetched) |=> !exc_take)
    else $error("exception taken before vector fetched");
  AST_PSEL_GUARD: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && !global_mask) |=> $stable(psel))
    else $error("promotion field changed while unmasked");
  AST_PUSH_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    (push_fire && !last_push) |=> push_idx == $past(push_idx) + 4'h1)
    else $error("push order broken");
  AST_GLOBAL_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    global_mask |-> !take_m)
    else $error("maskable taken under global mask");
endmodule // nmx_exception
`default_nettype wire

// ---- hw/nmx_pkg.sv ----
// nonmaskable exception logic: shared constants and types
// assumes a single 25 MHz bus clock and an AXI4-Lite register port
package nmx_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] NMX_OFS_CTRL = 4'h0;
  localparam logic [3:0] NMX_OFS_STATUS = 4'h4;
  localparam logic [3:0] NMX_OFS_LOCAL_EN = 4'h8;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int NMX_CCR_X_BIT = 6;
  localparam int NMX_NUM_SRC = 20;
  localparam int NMX_PSEL_W = 4;
  localparam logic [3:0] NMX_PSEL_RST = 4'h5;
  localparam logic [3:0] NMX_PSEL_RESERVED = 4'h5;
  localparam logic [4:0] NMX_SRC_IRQ_PIN = 5'h06;
  localparam logic [19:0] NMX_LOCAL_EN_RST = 20'h00000;
  localparam logic [7:0] NMX_OP_PROBE = 8'h00;
  localparam logic [1:0] NMX_PAGE_BASE = 2'h0;
  localparam logic [3:0] NMX_LAST_PUSH = 4'h8;
  localparam int NMX_ST_X = 0;
  localparam int NMX_ST_STOPPED = 1;
  localparam int NMX_ST_BUSY = 2;
  localparam int NMX_ST_MPEND = 3;
  localparam int NMX_ST_PIN = 4;
  localparam int NMX_ST_SRC_LSB = 8;
  // ------------------------------------------------------------
  // axi responses
  // ------------------------------------------------------------
  localparam logic [1:0] NMX_RESP_OKAY = 2'h0;
  localparam logic [1:0] NMX_RESP_DECERR = 2'h3;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    NMX_EXC_NONMASK,
    NMX_EXC_ILLEGAL,
    NMX_EXC_TRAP,
    NMX_EXC_MASKABLE
  } nmx_exc_t;
  // push order: pc lo, pc hi, y lo, y hi, x lo, x hi, acc a, acc b, ccr
  typedef enum logic [3:0] {
    NMX_PUSH_PCL, NMX_PUSH_PCH, NMX_PUSH_IYL, NMX_PUSH_IYH, NMX_PUSH_IXL,
    NMX_PUSH_IXH, NMX_PUSH_ACCA, NMX_PUSH_ACCB, NMX_PUSH_CCR
  } nmx_push_t;
endpackage

// ---- verif/nmx_seq_model.sv ----
// sequencer-side partner: answers stacking pushes and vector fetches
// assumes the exception block's clock, reset and stacking handshake
`timescale 1ns/1ps
`default_nettype none
module nmx_seq_model import nmx_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // exception side
  input wire logic exc_take,
  input wire logic push_valid,
  input wire nmx_push_t push_sel,
  input wire logic push_ccr_x,
  input wire logic set_global_mask,
  input wire logic vector_req,
  output logic push_ready,
  output logic vector_fetched,
  // pacing and record
  input wire logic slow,
  output logic [3:0] pushes,
  output logic order_ok,
  output logic ccr_x,
  output logic gm_at_ccr
);
  // ------------------------------------------------------------
  // answers every cycle, or one cycle in four when slow
  // ------------------------------------------------------------
  logic [1:0] pace;
  logic go;
  assign go = !slow || pace == 2'h3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace <= 2'h0;
      push_ready <= 1'b0;
      vector_fetched <= 1'b0;
      pushes <= 4'h0;
      order_ok <= 1'b1;
      ccr_x <= 1'b0;
      gm_at_ccr <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      push_ready <= push_valid && go;
      vector_fetched <= vector_req && !vector_fetched && go;
      if (exc_take) begin
        pushes <= 4'h0;
        order_ok <= 1'b1;
      end else if (push_valid && push_ready) begin
        pushes <= pushes + 4'h1;
        if (push_sel !== nmx_push_t'(pushes)) order_ok <= 1'b0;
        if (push_sel == NMX_PUSH_CCR) begin
          ccr_x <= push_ccr_x;
          gm_at_ccr <= set_global_mask;
        end
      end
    end
  end
endmodule // nmx_seq_model
`default_nettype wire

// ---- verif/test_nonmaskable_exception_logic.sv ----
// self-checking bench for the nonmaskable exception logic
// assumes nmx_pkg, nmx_exception and nmx_seq_model
`timescale 1ns/1ps
`default_nettype none
module test_nonmaskable_exception_logic import nmx_pkg::*; ;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb, pushes;
  logic [1:0] bresp, rresp, rr, op_page;
  logic nonmaskable_request_pin_n, irq_pin_n, special_mode, global_mask, insn_boundary, stop_exec;
  logic op_fetch, op_implemented, ccr_write, software_trap_op_start, vector_fetched, trap_fetch_ok;
  logic exc_take, push_valid, push_ready, push_ccr_x, set_global_mask, vector_req, clk_run, resume_pulse;
  logic mask_flag, slow, order_ok, ccr_x, gm_at_ccr;
  logic [19:0] src_req;
  logic [7:0] op_code, ccr_wdata;
  logic [15:0] op_addr, exc_return_addr;
  logic [4:0] exc_src;
  nmx_exc_t exc_kind;
  nmx_push_t push_sel;
  int bad_count, total_checks;
  nmx_exception dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
    .rresp, .nonmaskable_request_pin_n, .irq_pin_n, .special_mode, .global_mask, .insn_boundary, .stop_exec,
    .src_req, .op_fetch, .op_page, .op_code, .op_implemented, .op_addr, .ccr_write, .ccr_wdata,
    .software_trap_op_start, .vector_fetched, .trap_fetch_ok, .exc_take, .exc_kind, .exc_return_addr, .exc_src,
    .push_valid, .push_ready, .push_sel, .push_ccr_x, .set_global_mask, .vector_req, .clk_run, .resume_pulse,
    .mask_flag);
  nmx_seq_model seq (.aclk, .aresetn, .exc_take, .push_valid, .push_sel, .push_ccr_x, .set_global_mask,
    .vector_req, .push_ready, .vector_fetched, .slow, .pushes, .order_ok, .ccr_x, .gm_at_ccr);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic timeout_hit;
    chk(32'h0, 32'h1);
    tally_and_finish;
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) timeout_hit;
    chk(bresp, er);
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (rvalid !== 1'b1) timeout_hit;
  endtask
  task automatic quiet(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge aclk);
      if (exc_take === 1'b1) c++;
      @(posedge aclk);
      insn_boundary <= 1'b0;
    end
    chk(c, 0);
  endtask
  task automatic take(input nmx_exc_t k, input logic x, input logic poke);
    int n, extra;
    n = 0;
    extra = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (exc_take !== 1'b1 && n < 40);
    if (exc_take !== 1'b1) timeout_hit;
    n = 0;
    do begin
      @(posedge aclk);
      insn_boundary <= poke && push_valid && !insn_boundary;
      software_trap_op_start <= 1'b0;
      if (poke) {global_mask, src_req} <= {1'b0, 20'h00040};
      @(negedge aclk);
      if (exc_take === 1'b1) extra++;
      n++;
    end while (!(pushes == 4'h9 && !push_valid && !vector_req) && n < 200);
    if (n >= 200) timeout_hit;
    chk(exc_kind, k);
    chk(order_ok, 1'b1);
    chk(extra, 0);
    chk(ccr_x, x);
    chk(gm_at_ccr, 1'b1);
  endtask
  task automatic condition_code_reg(input logic [7:0] d);
    @(posedge aclk);
    {ccr_write, ccr_wdata} <= {1'b1, d};
    @(posedge aclk);
    ccr_write <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic fetch(input logic [1:0] pg, input logic [7:0] op, input logic im, input logic [15:0] ad,
      input logic sm);
    @(posedge aclk);
    {op_fetch, op_page, op_code, op_implemented, op_addr, special_mode} <= {1'b1, pg, op, im, ad, sm};
    @(posedge aclk);
    op_fetch <= 1'b0;
    insn_boundary <= 1'b1;
  endtask
  task automatic stop(input logic xpin);
    @(posedge aclk);
    stop_exec <= 1'b1;
    @(posedge aclk);
    stop_exec <= 1'b0;
    quiet(6);
    chk(clk_run, 1'b0);
    @(posedge aclk);
    if (xpin) nonmaskable_request_pin_n <= 1'b0;
    else irq_pin_n <= 1'b0;
  endtask
  task automatic resume;
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (resume_pulse !== 1'b1 && n < 20);
    if (resume_pulse !== 1'b1) timeout_hit;
    quiet(3);
    chk(clk_run, 1'b1);
    @(posedge aclk);
    {nonmaskable_request_pin_n, irq_pin_n} <= 2'h3;
    quiet(4);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_flag;
    @(negedge aclk);
    chk(mask_flag, 1'b1);
    axr(NMX_OFS_CTRL, rd, rr);
    chk(rd[3:0], NMX_PSEL_RST);
    condition_code_reg(8'hff);
    chk(mask_flag, 1'b1);
    condition_code_reg(8'hbf);
    chk(mask_flag, 1'b0);
    condition_code_reg(8'h40);
    chk(mask_flag, 1'b0);
    @(posedge aclk);
    nonmaskable_request_pin_n <= 1'b0;
    quiet(8);
    @(posedge aclk);
    insn_boundary <= 1'b1;
    take(NMX_EXC_NONMASK, 1'b0, 1'b0);
    chk(mask_flag, 1'b1);
    @(posedge aclk);
    insn_boundary <= 1'b1;
    quiet(4);
    @(posedge aclk);
    nonmaskable_request_pin_n <= 1'b1;
    quiet(4);
  endtask
  task automatic t_illegal;
    for (int p = 0; p < 4; p++) begin
      fetch(p[1:0], 8'h41, 1'b0, 16'h2000 + 16'(p * 3), 1'b0);
      take(NMX_EXC_ILLEGAL, 1'b1, 1'b0);
      chk(exc_return_addr, 16'h2000 + 16'(p * 3));
    end
    fetch(2'h0, NMX_OP_PROBE, 1'b1, 16'h2100, 1'b0);
    take(NMX_EXC_ILLEGAL, 1'b1, 1'b0);
    fetch(2'h0, NMX_OP_PROBE, 1'b1, 16'h2100, 1'b1);
    quiet(4);
  endtask
  task automatic t_trap;
    @(posedge aclk);
    {global_mask, src_req, special_mode} <= {1'b0, 20'h00040, 1'b0};
    repeat (2) @(negedge aclk);
    chk(trap_fetch_ok, 1'b0);
    @(posedge aclk);
    {global_mask, src_req} <= {1'b1, 20'h0};
    repeat (2) @(negedge aclk);
    chk(trap_fetch_ok, 1'b1);
    @(posedge aclk);
    {slow, software_trap_op_start} <= 2'h3;
    take(NMX_EXC_TRAP, 1'b1, 1'b1);
    @(posedge aclk);
    {slow, insn_boundary} <= 2'h1;
    take(NMX_EXC_MASKABLE, 1'b1, 1'b0);
    chk(exc_src, NMX_SRC_IRQ_PIN);
    @(posedge aclk);
    {global_mask, src_req} <= {1'b1, 20'h0};
  endtask
  task automatic t_stop;
    fetch(2'h0, 8'h01, 1'b1, 16'h3000, 1'b0);
    quiet(2);
    stop(1'b1);
    resume;
    stop(1'b0);
    resume;
    condition_code_reg(8'h00);
    stop(1'b1);
    take(NMX_EXC_NONMASK, 1'b0, 1'b0);
    @(posedge aclk);
    nonmaskable_request_pin_n <= 1'b1;
    quiet(4);
  endtask
  task automatic t_prio;
    axw(NMX_OFS_CTRL, 32'h9, NMX_RESP_OKAY);
    axw(NMX_OFS_LOCAL_EN, 32'h204, NMX_RESP_OKAY);
    @(posedge aclk);
    src_req <= 20'h01204;
    axr(NMX_OFS_STATUS, rd, rr);
    chk(rd[27:8], 20'h00204);
    @(posedge aclk);
    global_mask <= 1'b0;
    axw(NMX_OFS_CTRL, 32'h0, NMX_RESP_OKAY);
    axr(NMX_OFS_CTRL, rd, rr);
    chk(rd[3:0], 4'h9);
    @(posedge aclk);
    insn_boundary <= 1'b1;
    take(NMX_EXC_MASKABLE, 1'b1, 1'b0);
    chk(exc_src, 5'h09);
    @(posedge aclk);
    {src_req, insn_boundary} <= {20'h01004, 1'b1};
    take(NMX_EXC_MASKABLE, 1'b1, 1'b0);
    chk(exc_src, 5'h02);
    @(posedge aclk);
    {global_mask, src_req} <= {1'b1, 20'h0};
    axr(32'hc, rd, rr);
    chk(rr, NMX_RESP_DECERR);
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, special_mode, insn_boundary, stop_exec} = '0;
    {op_fetch, op_implemented, ccr_write, software_trap_op_start, slow} = '0;
    {awaddr, wdata, araddr, src_req, op_page, op_code, ccr_wdata, op_addr} = '0;
    {nonmaskable_request_pin_n, irq_pin_n, global_mask} = 3'h7;
    wstrb = 4'hf;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_flag;
    t_illegal;
    t_trap;
    t_stop;
    t_prio;
    condition_code_reg(8'h00);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(mask_flag, 1'b1);
    tally_and_finish;
  end
endmodule // test_nonmaskable_exception_logic
`default_nettype wire
